// >>> rtl/cws_cfg.svh
// Purpose: constants for the command word sequencer
// Assumes: 15-bit word elements, 3/6/6 field split
// Notes: included by the package and the design files
`ifndef CWS_CFG_SVH
`define CWS_CFG_SVH
`define CWS_WORD_W 15
`define CWS_AOPT_MSB 14
`define CWS_AOPT_LSB 12
`define CWS_PCMD_MSB 11
`define CWS_PCMD_LSB 6
`define CWS_SEC_MSB 5
`define CWS_SEC_LSB 0
`define CWS_DIRECT_LEN 3'h4
`define CWS_INDIRECT_LEN 3'h6
`define CWS_HOLD_CLK_D 3'h3
`define CWS_HOLD_CLK_I 3'h5
`define CWS_OP_COMP_C1 6'h01
`define CWS_OP_COMP_C0 6'h02
`define CWS_OP_ADD 6'h03
`define CWS_OP_SWAP_AP 6'h04
`define CWS_OP_AND_INV 6'h05
`define CWS_OP_OR 6'h06
`define CWS_OP_HOLD_A 6'h07
`define CWS_OP_HOLD_P 6'h08
`define CWS_OP_MULT 6'h09
`define CWS_OP_DIV 6'h0A
`define CWS_OP_SHIFT 6'h0B
`define CWS_OP_FLOAT 6'h0C
`define CWS_OP_RPT 6'h0D
`define CWS_OP_JUMP 6'h0E
`define CWS_OP_SKIP 6'h0F
`define CWS_OP_WIO 6'h10
`define CWS_OP_EXT 6'h11
`define CWS_RESET_WORD 15'h0000
`endif

// >>> rtl/cws_pkg.sv
// Purpose: shared types for the command word sequencer
// Assumes: constants come from cws_cfg.svh
// Notes: memory request travels as one packed struct
`include "cws_cfg.svh"
package cws_pkg;
  typedef logic [`CWS_WORD_W-1:0] cws_word_type;
  // Memory request toward core through the exchange register
  typedef struct packed {
    logic rd;
    logic wr;
    cws_word_type addr;
    cws_word_type wdata;
  } cws_mreq_type;
  // Command word fields
  typedef struct packed {
    logic [2:0] addressOptionField;
    logic [5:0] primaryCommandField;
    logic [5:0] secondaryField;
  } cws_cword_type;
endpackage : cws_pkg

// >>> rtl/cws_sequencer.sv
// Purpose: run primary and secondary command fields of each word
// Assumes: memory answers rdValid in the cycle of the read strobe; ioSync from pins
// Notes: accumulator, pointer register and carry live here
`include "cws_cfg.svh"
module cws_sequencer #(
  parameter int WORD_W = `CWS_WORD_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Memory side through exchange register
  output cws_pkg::cws_mreq_type memReq,
  input wire cws_pkg::cws_word_type memRdata,
  input wire logic memRdValid,
  // Hold release inputs
  input wire logic ioSyncPin,
  input wire logic [7:0] repeatCount,
  // State shown outward
  output cws_pkg::cws_word_type accOut,
  output cws_pkg::cws_word_type ptrOut,
  output cws_pkg::cws_word_type cmdWordOut,
  output logic carryOut,
  output logic holdingOut,
  output logic badCmdOut
);
  import cws_pkg::*;
  //////////////////////////////////////////////////////////////////////
  // Declarations
  cws_word_type acc_reg; // Accumulator
  cws_word_type ptr_reg; // Auxiliary pointer / shift register
  cws_word_type mar_reg; // Memory address register
  cws_word_type mx_reg; // Memory exchange register
  cws_cword_type cw_reg; // Command word register
  logic carry_reg; // Carry indicator
  logic hold_reg; // Holding in a control state
  logic bad_reg; // Illegal field use seen
  logic [7:0] cnt_reg; // Iteration counter for holds
  cws_mreq_type req_reg; // Memory request register
  logic sync1_reg, sync2_reg; // Pin synchroniser
  logic [2:0] clkNum; // Current clock of word cycle
  logic indirect; // Indirect address option
  logic [2:0] cycLen; // Cycle length in clocks
  logic lastClk; // Final clock of this word
  logic [5:0] pcmd, scmd; // Fields of current word
  logic holdCmd; // Primary command that holds
  logic extCmd; // Extended special word
  logic secOk; // Secondary field is a command
  logic holdDone; // Hold released this cycle
  cws_word_type acc_next; // Accumulator after both fields
  cws_word_type ptr_next; // Pointer after both fields
  logic carry_next; // Carry after both fields
  cws_word_type swapTmp; // Scratch for a secondary swap
  //////////////////////////////////////////////////////////////////////
  // Field decode
  assign pcmd = cw_reg.primaryCommandField;
  assign scmd = cw_reg.secondaryField;
  assign indirect = cw_reg.addressOptionField[2];
  // Jump and skip keep the short cycle even with indirect options
  assign cycLen = (pcmd == `CWS_OP_JUMP || pcmd == `CWS_OP_SKIP) ?
    `CWS_DIRECT_LEN :
    (indirect ? `CWS_INDIRECT_LEN : `CWS_DIRECT_LEN);
  // Secondary may carry only the ops with secondary timing
  assign secOk = !cw_reg.addressOptionField[1] &&
    cw_reg.addressOptionField[0] &&
    (scmd == `CWS_OP_COMP_C1 || scmd == `CWS_OP_COMP_C0 ||
     scmd == `CWS_OP_ADD || scmd == `CWS_OP_SWAP_AP ||
     scmd == `CWS_OP_AND_INV || scmd == `CWS_OP_OR);
  assign holdCmd = (pcmd >= `CWS_OP_MULT && pcmd <= `CWS_OP_RPT) ||
    pcmd == `CWS_OP_WIO;
  assign extCmd = pcmd == `CWS_OP_EXT;
  assign lastClk = (clkNum == cycLen) && !hold_reg;
  assign holdDone = hold_reg && (pcmd == `CWS_OP_WIO ? sync2_reg :
    cnt_reg == 8'h00);
  //////////////////////////////////////////////////////////////////////
  // Clock counter; stalls while holding
  cws_step_timer u_timer (
    .sys_clk(sys_clk),
    .srst(srst),
    .advance(1'b1),
    .restart(lastClk || holdDone),
    .hold(hold_reg),
    .clkNum(clkNum)
  );
  //////////////////////////////////////////////////////////////////////
  // Pin synchroniser; first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= ioSyncPin;
      sync2_reg <= sync1_reg;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Fetch: clocks one and two read, restore, load word
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cw_reg <= `CWS_RESET_WORD;
      mar_reg <= `CWS_RESET_WORD;
    end else if (clkNum == 3'h2 && !hold_reg) begin
      cw_reg <= memRdata;
      mar_reg <= mar_reg + 15'h0001; // Next word in sequence
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Memory request per clock
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      req_reg <= '0;
    end else begin
      req_reg <= '0;
      if (clkNum == 3'h1 && !hold_reg) begin
        req_reg.rd <= 1'b1;
        req_reg.addr <= mar_reg;
      end else if (clkNum == 3'h2 && !hold_reg) begin
        req_reg.wr <= 1'b1; // Restore destructive read
        req_reg.addr <= mar_reg;
        req_reg.wdata <= memRdata;
      end else if (clkNum == cycLen - 3'h1 && !hold_reg && !extCmd) begin
        // Operand access; option transfers unused for extended
        if (pcmd == `CWS_OP_HOLD_A || pcmd == `CWS_OP_HOLD_P) begin
          req_reg.wr <= 1'b1;
          req_reg.wdata <= pcmd == `CWS_OP_HOLD_A ? acc_reg : ptr_reg;
        end else begin
          req_reg.rd <= 1'b1;
        end
        req_reg.addr <= indirect ? mx_reg : {9'h000, scmd};
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Exchange register captures read data
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mx_reg <= `CWS_RESET_WORD;
    end else if (memRdValid) begin
      mx_reg <= memRdata;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Holding state for sync or iteration counting
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hold_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else if (!hold_reg && holdCmd &&
      clkNum == (indirect ? `CWS_HOLD_CLK_I : `CWS_HOLD_CLK_D) &&
      (pcmd == `CWS_OP_WIO || !indirect)) begin
      hold_reg <= 1'b1;
      cnt_reg <= repeatCount;
    end else if (!hold_reg && extCmd && clkNum == 3'h3) begin
      hold_reg <= 1'b1; // Repeat control state
      cnt_reg <= repeatCount;
    end else if (holdDone) begin
      hold_reg <= 1'b0;
    end else if (hold_reg && cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Illegal use flag: long ops outside primary direct
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bad_reg <= 1'b0;
    end else if (clkNum == 3'h3 && !hold_reg) begin
      bad_reg <= indirect && pcmd >= `CWS_OP_MULT &&
        pcmd <= `CWS_OP_RPT;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Next accumulator, pointer and carry for the word in control
  // Secondary works on the primary's result, so it wins on A
  always_comb begin
    acc_next = acc_reg;
    ptr_next = ptr_reg;
    carry_next = carry_reg;
    swapTmp = acc_reg;
    unique case (pcmd)
      `CWS_OP_COMP_C1: begin
        acc_next = ~acc_reg;
        carry_next = 1'b1;
      end
      `CWS_OP_COMP_C0: begin
        acc_next = ~acc_reg;
        carry_next = 1'b0;
      end
      `CWS_OP_ADD: begin
        acc_next = acc_reg + mx_reg;
      end
      `CWS_OP_SWAP_AP: begin
        acc_next = ptr_reg;
        ptr_next = acc_reg;
      end
      `CWS_OP_AND_INV: begin
        acc_next = mx_reg & ~acc_reg;
      end
      `CWS_OP_OR: begin
        acc_next = mx_reg | acc_reg;
      end
      default: begin
        acc_next = acc_reg; // Other commands leave A alone
      end
    endcase
    // Only ops with secondary timing act from this field
    if (secOk) begin
      unique case (scmd)
        `CWS_OP_COMP_C1: begin
          acc_next = ~acc_next;
          carry_next = 1'b1;
        end
        `CWS_OP_COMP_C0: begin
          acc_next = ~acc_next;
          carry_next = 1'b0;
        end
        `CWS_OP_ADD: begin
          acc_next = acc_next + mx_reg;
        end
        `CWS_OP_SWAP_AP: begin
          swapTmp = acc_next;
          acc_next = ptr_next;
          ptr_next = swapTmp;
        end
        `CWS_OP_AND_INV: begin
          acc_next = mx_reg & ~acc_next;
        end
        default: begin
          acc_next = mx_reg | acc_next;
        end
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Accumulator, pointer and carry load at the final clock
  // Extended words keep their own transfers, so nothing loads here
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      acc_reg <= `CWS_RESET_WORD;
      ptr_reg <= `CWS_RESET_WORD;
      carry_reg <= 1'b0;
    end else if (lastClk && !extCmd) begin
      acc_reg <= acc_next;
      ptr_reg <= ptr_next;
      carry_reg <= carry_next;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Outputs from flip-flops
  assign memReq = req_reg;
  assign accOut = acc_reg;
  assign ptrOut = ptr_reg;
  assign cmdWordOut = cw_reg;
  assign carryOut = carry_reg;
  assign holdingOut = hold_reg;
  assign badCmdOut = bad_reg;
  //////////////////////////////////////////////////////////////////////
  // Checks
  a_fetch_read: assert property (
    @(posedge sys_clk) disable iff (srst)
    clkNum == 3'h1 && !hold_reg |=> memReq.rd)
    else $error("no fetch read at clock one");
  a_fetch_restore: assert property (
    @(posedge sys_clk) disable iff (srst)
    clkNum == 3'h2 && !hold_reg |=> memReq.wr)
    else $error("no restore at clock two");
  a_cycle_len: assert property (
    @(posedge sys_clk) disable iff (srst)
    clkNum <= cycLen)
    else $error("clock past cycle length");
  a_comp_carry: assert property (
    @(posedge sys_clk) disable iff (srst)
    lastClk && pcmd == `CWS_OP_COMP_C1 && !extCmd && !secOk
    |=> carry_reg && acc_reg == ~$past(acc_reg))
    else $error("complement wrong");
  a_add_sum: assert property (
    @(posedge sys_clk) disable iff (srst)
    lastClk && pcmd == `CWS_OP_ADD && !secOk
    |=> acc_reg == $past(acc_reg) + $past(mx_reg))
    else $error("add wrong");
  a_swap_pair: assert property (
    @(posedge sys_clk) disable iff (srst)
    lastClk && pcmd == `CWS_OP_SWAP_AP && !secOk
    |=> ptr_reg == $past(acc_reg))
    else $error("swap wrong");
  a_hold_stall: assert property (
    @(posedge sys_clk) disable iff (srst)
    hold_reg && !holdDone |=> $stable(clkNum))
    else $error("clock moved during hold");
  a_no_ext_op: assert property (
    @(posedge sys_clk) disable iff (srst)
    extCmd && clkNum > 3'h2 |=> !memReq.rd && !memReq.wr)
    else $error("option transfer in extended word");
  a_branch_short: assert property (
    @(posedge sys_clk) disable iff (srst)
    (pcmd == `CWS_OP_JUMP || pcmd == `CWS_OP_SKIP) && clkNum > 3'h2
    |-> clkNum <= 3'h4)
    else $error("jump or skip longer than four clocks");
  a_io_hold: assert property (
    @(posedge sys_clk) disable iff (srst)
    !hold_reg && pcmd == `CWS_OP_WIO &&
    clkNum == (indirect ? `CWS_HOLD_CLK_I : `CWS_HOLD_CLK_D)
    |=> hold_reg)
    else $error("word transfer did not hold");
  a_ext_hold: assert property (
    @(posedge sys_clk) disable iff (srst)
    !hold_reg && extCmd && clkNum == 3'h3 |=> hold_reg)
    else $error("extended word did not repeat its state");
  c_add: cover property (@(posedge sys_clk) lastClk && pcmd == `CWS_OP_ADD);
  c_hold: cover property (@(posedge sys_clk) holdDone);
  c_sec: cover property (@(posedge sys_clk) lastClk && secOk);
  c_ext_hold: cover property (@(posedge sys_clk) hold_reg && extCmd);
endmodule // cws_sequencer

// >>> rtl/cws_step_timer.sv
// Purpose: clock counter for one command word; the cycle-length compare is in the sequencer
// Assumes: restart pulses on the final clock of a word or at hold release
// Notes: count stays put while hold is high and restart is low
`include "cws_cfg.svh"
module cws_step_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Control
  input wire logic advance,
  input wire logic restart,
  input wire logic hold,
  // State
  output logic [2:0] clkNum
);
  import cws_pkg::*;
  logic [2:0] clk_reg;
  assign clkNum = clk_reg;
  // Clock number within the word cycle, 1-based
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clk_reg <= 3'h1;
    end else if (restart) begin
      clk_reg <= 3'h1;
    end else if (advance && !hold) begin
      clk_reg <= clk_reg + 3'h1;
    end
  end
endmodule // cws_step_timer

// >>> tb/cws_mem_model.sv
// Purpose: core memory behind the exchange register
// Assumes: prompt mode answers in the cycle of the read strobe
// Notes: slow mode answers one clock late
module cws_mem_model (
  // Clock and mode
  input wire logic sys_clk,
  input wire logic slow,
  // Request and answer
  input wire cws_pkg::cws_mreq_type memReq,
  output cws_pkg::cws_word_type memRdata,
  output logic memRdValid
);
  timeunit 1ns;
  timeprecision 1ps;
  import cws_pkg::*;
  cws_word_type mem [0:32767]; // Whole core
  cws_word_type last_reg = 15'h0000; // Last word handed out
  cws_word_type addr_reg = 15'h0000; // Address held for slow mode
  logic rdLate_reg = 1'b0; // Delayed strobe for slow mode
  ////////////////////////////////////////
  // Fill every cell with one word
  task automatic fill(input cws_word_type w);
    for (int i = 0; i < 32768; i++) mem[i] = w;
  endtask
  // Writes land at the edge; restore keeps the fetched word
  always @(posedge sys_clk) begin
    if (memReq.wr) mem[memReq.addr] <= memReq.wdata;
    rdLate_reg <= memReq.rd;
    addr_reg <= memReq.addr;
    if (memRdValid) last_reg <= memRdata;
  end
  // Idle bus shows the inverse of the last word, never a stale copy
  assign memRdValid = slow ? rdLate_reg : memReq.rd;
  assign memRdata = !memRdValid ? ~last_reg :
    mem[slow ? addr_reg : memReq.addr];
endmodule // cws_mem_model

// >>> tb/tb_command_word_sequencer.sv
// Purpose: self-checking bench for the command word sequencer
// Assumes: every core cell holds the word under test
// Notes: one restore write per word marks the cycle boundary
`include "cws_cfg.svh"
module tb_command_word_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import cws_pkg::*;
  logic sys_clk = 1'b0, srst = 1'b1, ioSyncPin = 1'b0, carryOut;
  logic [7:0] repeatCount = 8'h00; // Hold iteration count
  cws_mreq_type memReq;
  cws_word_type memRdata, accOut, ptrOut, cmdWordOut;
  logic memRdValid, holdingOut, badCmdOut;
  int errors = 0, n_checks = 0, seed = 80881, gap, g1, rise, hi, r1;
  logic [5:0] ops [7] = '{`CWS_OP_COMP_C1, `CWS_OP_COMP_C0, `CWS_OP_ADD,
    `CWS_OP_AND_INV, `CWS_OP_OR, `CWS_OP_JUMP, `CWS_OP_SKIP};
  logic [5:0] hops [5] = '{`CWS_OP_MULT, `CWS_OP_DIV, `CWS_OP_SHIFT,
    `CWS_OP_FLOAT, `CWS_OP_RPT};
  logic [2:0] opts [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
  cws_word_type hw [5] = '{{3'h1, `CWS_OP_ADD, `CWS_OP_COMP_C1},
    {3'h1, 6'h00, `CWS_OP_ADD}, {3'h1, 6'h00, `CWS_OP_JUMP},
    {3'h1, 6'h00, `CWS_OP_HOLD_A}, {3'h1, `CWS_OP_SWAP_AP, `CWS_OP_ADD}};
  cws_cword_type c;
  logic [2:0] o;
  always #5 sys_clk = ~sys_clk; // 100 MHz
  cws_sequencer uut (.sys_clk(sys_clk), .srst(srst), .memReq(memReq),
    .memRdata(memRdata), .memRdValid(memRdValid), .ioSyncPin(ioSyncPin),
    .repeatCount(repeatCount), .accOut(accOut), .ptrOut(ptrOut),
    .cmdWordOut(cmdWordOut), .carryOut(carryOut), .holdingOut(holdingOut),
    .badCmdOut(badCmdOut));
  cws_mem_model mdl (.sys_clk(sys_clk), .slow(1'b0), .memReq(memReq),
    .memRdata(memRdata), .memRdValid(memRdValid));
  ////////////////////////////////////////
  // Compare tasks, one per kind of result
  task automatic cmp_w(input string s, input cws_word_type e, g);
    n_checks++;
    if (g !== e) begin errors++; $display("MISMATCH %s %h %h", s, e, g); end
  endtask
  task automatic cmp_i(input string s, input int e, g);
    n_checks++;
    if (g != e) begin errors++; $display("MISMATCH %s %0d %0d", s, e, g); end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Fill core, hold reset 16 clocks, set hold inputs
  task automatic start(input cws_word_type w, input logic [7:0] r,
      input logic s);
    @(posedge sys_clk);
    srst <= 1'b1;
    repeatCount <= r;
    ioSyncPin <= s;
    // Let the last pending write drain before the core is refilled
    repeat (2) @(posedge sys_clk);
    mdl.fill(w);
    repeat (14) @(posedge sys_clk);
    srst <= 1'b0;
  endtask
  // Next write strobe, bounded; gap counts clocks
  task automatic wait_wr(output int g);
    g = 0;
    do begin @(negedge sys_clk); g++; end
    while (memReq.wr !== 1'b1 && g < 40);
    if (g >= 40) cmp_i("write strobe", 0, g);
  endtask
  // Expected effect of one command on accumulator, pointer, carry
  task automatic apply(input logic [5:0] op, input cws_word_type w,
      inout cws_word_type a, p, inout logic cy, ok);
    cws_word_type t;
    t = a;
    case (op)
      `CWS_OP_COMP_C1: begin a = ~a; cy = 1'b1; ok = 1'b1; end
      `CWS_OP_COMP_C0: begin a = ~a; cy = 1'b0; ok = 1'b1; end
      `CWS_OP_ADD: begin a = a + w; ok = 1'b0; end
      `CWS_OP_SWAP_AP: begin a = p; p = t; end
      `CWS_OP_AND_INV: a = w & ~a;
      `CWS_OP_OR: a = w | a;
      default: ; // No timing here means no effect
    endcase
  endtask
  // Run n words of one kind, checking each boundary
  task automatic run_seq(input cws_cword_type w, input int n);
    cws_word_type a, p;
    logic cy, ok;
    int len;
    a = '0; p = '0; cy = 1'b0; ok = 1'b1;
    len = (w.primaryCommandField inside {`CWS_OP_JUMP, `CWS_OP_SKIP}) ? 4 :
      (w.addressOptionField[2] ? 6 : 4);
    start(w, 8'h00, 1'b0);
    for (int k = 0; k < n; k++) begin
      wait_wr(gap);
      if (k > 0) cmp_i("cycle length", len, gap);
      cmp_w("command word", w, cmdWordOut);
      cmp_w("accumulator", a, accOut);
      if (w.addressOptionField == 3'h1) cmp_w("pointer", p, ptrOut);
      if (ok) cmp_w("carry", 15'(cy), 15'(carryOut));
      apply(w.primaryCommandField, w, a, p, cy, ok);
      if (w.addressOptionField[1:0] == 2'b01)
        apply(w.secondaryField, w, a, p, cy, ok);
    end
  endtask
  // Time to enter a hold, then time spent in it
  task automatic hold_run(input cws_word_type w, input logic [7:0] r,
      input logic s);
    start(w, r, s);
    rise = 0;
    hi = 0;
    while (holdingOut !== 1'b1 && rise < 16) begin
      @(negedge sys_clk);
      rise++;
    end
    while (holdingOut === 1'b1 && hi < 40) begin
      @(negedge sys_clk);
      hi++;
    end
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    foreach (ops[i]) begin
      run_seq({3'h1, ops[i], 6'h00}, 5);
      run_seq({3'h5, ops[i], 6'h00}, 5);
    end
    foreach (hw[i]) run_seq(hw[i], 5);
    // Random words; option choices leave the accumulator predictable
    repeat (20) begin
      o = opts[$unsigned($random(seed)) % 5];
      c.addressOptionField = o;
      c.primaryCommandField = ops[$unsigned($random(seed)) % 7];
      c.secondaryField = (o[1:0] == 2'b01) ?
        ops[$unsigned($random(seed)) % 5] : 6'($random(seed));
      run_seq(c, 4);
    end
    // Store: restore write then a write of the accumulator
    for (int k = 0; k < 2; k++) begin
      start({k ? 3'h5 : 3'h1, `CWS_OP_HOLD_A, 6'h00}, 8'h00, 1'b0);
      wait_wr(gap);
      wait_wr(g1);
      cmp_w("stored word", 15'h0000, memReq.wdata);
      wait_wr(gap);
      cmp_i("store cycle", k ? 6 : 4, g1 + gap);
    end
    // Long commands hold for a bounded count
    foreach (hops[i]) begin
      r1 = 2 + $unsigned($random(seed)) % 8;
      hold_run({3'h1, hops[i], 6'h00}, 8'(r1), 1'b1);
      cmp_i("long hold entered", 1, int'(rise < 16));
      cmp_i("long hold bounded", 1, int'(hi > 0 && hi <= r1 + 4));
      cmp_w("illegal use flag", 15'h0000, 15'(badCmdOut));
    end
    hold_run({3'h5, `CWS_OP_MULT, 6'h00}, 8'h04, 1'b1);
    cmp_i("indirect long op held", 0, int'(rise < 16));
    cmp_w("illegal use flag", 15'h0001, 15'(badCmdOut));
    // Extended word repeats a control state for a bounded count
    hold_run({3'h1, `CWS_OP_EXT, 6'h00}, 8'h03, 1'b0);
    cmp_i("extended hold entered", 1, int'(rise < 16));
    cmp_i("extended hold bounded", 1, int'(hi > 0 && hi <= 7));
    // Word I/O holds until sync, two clocks later when indirect
    for (int k = 0; k < 2; k++) begin
      hold_run({k ? 3'h5 : 3'h1, `CWS_OP_WIO, 6'h00}, 8'h02, 1'b0);
      if (k == 0) r1 = rise;
      else cmp_i("indirect hold start", r1 + 2, rise);
      cmp_i("io hold waits", 40, hi);
      @(posedge sys_clk);
      ioSyncPin <= 1'b1;
      hi = 0;
      while (holdingOut === 1'b1 && hi < 20) begin
        @(negedge sys_clk);
        hi++;
      end
      cmp_i("io hold released", 1, int'(hi < 8));
    end
    end_of_test();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    end_of_test();
  end
endmodule // tb_command_word_sequencer
